// file: core/spgw_core.sv
// Purpose: spi eeprom front end with power-up state and inadvertent write guard
// Assumes: host is spi mode 0 master; pins are asynchronous and synchronised here
// Notes: power-up is modelled by the asynchronous reset
// Contract
// R1: after power-up sit in standby and run no instruction until selected
// R2: only a chip-select falling edge starts accepting an instruction
// R3: serial output floats after power-up until a read drives it
// R4: write-enable latch cleared at power-up
// R5: flag bit cleared to zero at power-up
// R6: reset output held active for the power-up interval, then released
// R7: power-up reset interval nominally 200 ms, within 100 to 400 ms
// R8: nonvolatile writes refused unless the write-enable latch is set
// R9: write cycle starts only if select rises on a byte boundary
// R10: host raises select only after bit 0 of last data byte
// R11: writes into block-protected regions are refused
// R12: protect bits select none, top quarter, top half or whole array
// R13: write-protect pin low blocks array and status writes
// R14: self-timed write ends within 10 ms of the closing select edge
// R15: write-busy bit reads one exactly while the self-timed write runs
// R16: asynchronous reset sets every power-up state at once
`timescale 1ns/1ps
module spgw_core
    import spgw_pkg::*;
#(
    parameter int P_POR_CYC = POWERUP_RESET_CYC,
    parameter int P_NV_CYC = NV_WRITE_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_cs_n,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_flag_set,
    output logic o_so,
    output logic o_so_oe,
    output logic o_rst_n,
    output logic o_write_busy_bit,
    output logic o_write_enable_latch_bit,
    output logic o_flag,
    output logic [1:0] o_protect_sel
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_prot(input logic [1:0] bp, input logic [8:0] a);
        case (bp)
            BP_NONE: is_prot = 1'b0;
            BP_QUARTER: is_prot = (a >= QUARTER_BASE);
            BP_HALF: is_prot = (a >= HALF_BASE);
            default: is_prot = 1'b1;
        endcase
    endfunction

    spgw_regs_t s_ff;
    spgw_regs_t nxt_s;
    logic cs_low;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic wp_ok;
    logic [7:0] status;
    logic [7:0] rx;

    assign cs_low = ~s_ff.cs_sy[1];
    assign cs_fall = s_ff.cs_sy[2] & ~s_ff.cs_sy[1];
    assign cs_rise = ~s_ff.cs_sy[2] & s_ff.cs_sy[1];
    assign sck_rise = ~s_ff.sck_sy[2] & s_ff.sck_sy[1];
    assign sck_fall = s_ff.sck_sy[2] & ~s_ff.sck_sy[1];
    assign wp_ok = s_ff.wp_sy[1];
    assign status = {2'h0, s_ff.wd, s_ff.bp, s_ff.wlatch, s_ff.busy};
    assign rx = {s_ff.shreg[6:0], s_ff.si_sy[1]};

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_s = s_ff;
        // first stage is read only by the second
        nxt_s.cs_sy = {s_ff.cs_sy[1], s_ff.cs_sy[0], i_cs_n};
        nxt_s.sck_sy = {s_ff.sck_sy[1], s_ff.sck_sy[0], i_sck};
        nxt_s.si_sy = {s_ff.si_sy[0], i_si};
        nxt_s.wp_sy = {s_ff.wp_sy[0], i_wp_n};
        if (!s_ff.rst_n) begin
            nxt_s.por_cnt = 32'(s_ff.por_cnt + 32'h1);
            if (s_ff.por_cnt == 32'(P_POR_CYC - 1)) begin
                nxt_s.rst_n = 1'b1; // R6 R7
            end
        end
        if (i_flag_set) begin
            nxt_s.flag = 1'b1;
        end
        if (!wp_ok) begin
            nxt_s.wlatch = 1'b0; // R13
        end
        if (s_ff.busy) begin
            nxt_s.wr_cnt = 32'(s_ff.wr_cnt + 32'h1);
            if (s_ff.wr_cnt == 32'(P_NV_CYC - 1)) begin
                // commit only at the end of the count; a power cycle mid-write zeroes the whole array with the rest of s_ff
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    if (s_ff.mask[i]) begin
                        nxt_s.mem[{s_ff.addr[8:4], 4'(i)}] = s_ff.pbuf[i]; // R14
                    end
                end
                if (s_ff.sr_pend) begin
                    nxt_s.wd = s_ff.sr_data[SR_WD_LSB +: 2];
                    nxt_s.bp = s_ff.sr_data[SR_BP_LSB +: 2];
                end
                nxt_s.busy = 1'b0; // R15
                nxt_s.wlatch = 1'b0;
                nxt_s.mask = '0;
                nxt_s.sr_pend = 1'b0;
            end
        end
        if (cs_rise) begin
            if (s_ff.state == ST_WR && s_ff.bitcnt == 3'h0 && (|s_ff.mask) && s_ff.wlatch && wp_ok) begin
                nxt_s.busy = 1'b1; // R9 R8
                nxt_s.wr_cnt = '0;
            end else if (s_ff.state == ST_WRSR && s_ff.bitcnt == 3'h0 && s_ff.got_byte
                         && s_ff.wlatch && wp_ok) begin
                nxt_s.busy = 1'b1; // R9 R8 R13
                nxt_s.wr_cnt = '0;
                nxt_s.sr_pend = 1'b1;
            end else if (!s_ff.busy) begin
                nxt_s.mask = '0; // R9
            end
            nxt_s.state = ST_IDLE;
            nxt_s.so_oe = 1'b0;
        end else if (cs_fall) begin
            nxt_s.state = ST_CMD; // R1 R2
            nxt_s.bitcnt = '0;
            nxt_s.got_byte = 1'b0;
        end else if (cs_low && sck_rise && s_ff.state != ST_IDLE) begin
            nxt_s.shreg = rx;
            nxt_s.bitcnt = 3'(s_ff.bitcnt + 3'h1);
            if (s_ff.bitcnt == LAST_BIT) begin
                case (s_ff.state)
                    ST_CMD: begin
                        nxt_s.state = ST_IGNORE;
                        if (s_ff.busy && rx != STATUS_READ_CMD) begin
                            nxt_s.state = ST_IGNORE;
                        end else if (rx == WRITE_LATCH_SET_CMD) begin
                            nxt_s.wlatch = wp_ok; // R8 R13
                        end else if (rx == WRITE_LATCH_CLR_CMD) begin
                            nxt_s.wlatch = 1'b0;
                        end else if (rx == STATUS_READ_CMD) begin
                            nxt_s.tx = status;
                            nxt_s.state = ST_RDSR;
                            nxt_s.so_oe = 1'b1;
                        end else if (rx == STATUS_WRITE_CMD) begin
                            nxt_s.state = ST_WRSR;
                        end else if ((rx & ARRAY_OP_MASK) == ARRAY_READ_CMD ||
                                     (rx & ARRAY_OP_MASK) == ARRAY_WRITE_CMD) begin
                            nxt_s.a8 = rx[OP_A8_BIT];
                            nxt_s.op_rd = ((rx & ARRAY_OP_MASK) == ARRAY_READ_CMD);
                            nxt_s.state = ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        if (s_ff.op_rd) begin
                            nxt_s.tx = s_ff.mem[{s_ff.a8, rx}];
                            nxt_s.addr = 9'({s_ff.a8, rx} + 9'h1);
                            nxt_s.state = ST_RD;
                            nxt_s.so_oe = 1'b1; // R3
                        end else begin
                            nxt_s.addr = {s_ff.a8, rx};
                            nxt_s.mask = '0;
                            nxt_s.state = ST_WR;
                        end
                    end
                    ST_RD: begin
                        nxt_s.tx = s_ff.mem[s_ff.addr];
                        nxt_s.addr = 9'(s_ff.addr + 9'h1);
                    end
                    ST_RDSR: begin
                        nxt_s.tx = status;
                    end
                    ST_WR: begin
                        // protected bytes are dropped, the rest of the page still goes
                        if (s_ff.wlatch && wp_ok && !is_prot(s_ff.bp, s_ff.addr)) begin
                            nxt_s.pbuf[s_ff.addr[3:0]] = rx; // R11 R12
                            nxt_s.mask[s_ff.addr[3:0]] = 1'b1;
                        end
                        nxt_s.addr[3:0] = 4'(s_ff.addr[3:0] + 4'h1);
                    end
                    ST_WRSR: begin
                        if (!s_ff.got_byte) begin
                            nxt_s.sr_data = rx;
                        end
                        nxt_s.got_byte = 1'b1;
                    end
                    default: begin
                        nxt_s.state = ST_IGNORE;
                    end
                endcase
            end
        end else if (cs_low && sck_fall && s_ff.so_oe) begin
            nxt_s.so = s_ff.tx[7];
            nxt_s.tx = {s_ff.tx[6:0], 1'b0};
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            s_ff <= '0; // R16 R1 R3 R4 R5 R6
            s_ff.cs_sy <= 3'h7;
            s_ff.wd <= WD_DEFAULT;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_so = s_ff.so;
    assign o_so_oe = s_ff.so_oe;
    assign o_rst_n = s_ff.rst_n;
    assign o_write_busy_bit = s_ff.busy;
    assign o_write_enable_latch_bit = s_ff.wlatch;
    assign o_flag = s_ff.flag;
    assign o_protect_sel = s_ff.bp;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    a_por_release: assert property ($rose(s_ff.rst_n) |-> $past(s_ff.por_cnt) == 32'(P_POR_CYC - 1)) // R6 R7
        else $error("reset released at wrong count");
    a_so_float: assert property (s_ff.so_oe |-> (s_ff.state == ST_RD || s_ff.state == ST_RDSR)) // R3
        else $error("output driven outside a read");
    a_wp_clears: assert property (!wp_ok |=> !s_ff.wlatch) // R13
        else $error("latch kept while protect pin low");
    a_busy_start: assert property ($rose(s_ff.busy) |-> $past(s_ff.wlatch) && $past(wp_ok) && s_ff.wr_cnt == 32'h0) // R8
        else $error("write started without latch");
    a_busy_end: assert property ($fell(s_ff.busy) |-> $past(s_ff.wr_cnt) == 32'(P_NV_CYC - 1) && !s_ff.wlatch) // R14 R15
        else $error("write cycle length wrong");
    a_idle_hold: assert property ((s_ff.state == ST_IDLE && !cs_fall) |=> s_ff.state == ST_IDLE) // R1 R2
        else $error("left standby without select edge");
    a_byte_bound: assert property ($rose(s_ff.busy) |-> $past(cs_rise) && $past(s_ff.bitcnt) == 3'h0) // R9
        else $error("write started off a byte boundary");
    a_prot_skip: assert property ((s_ff.state == ST_WR && cs_low && sck_rise && !cs_rise && !cs_fall
        && s_ff.bitcnt == LAST_BIT && is_prot(s_ff.bp, s_ff.addr)) |=> s_ff.mask == $past(s_ff.mask)) // R11 R12
        else $error("protected byte buffered");

    c_write_cycle: cover property ($fell(s_ff.busy));
    c_por_done: cover property ($rose(s_ff.rst_n));
    c_read_out: cover property ($rose(s_ff.so_oe));
endmodule // spgw_core

// file: pkg/spgw_pkg.sv
// Purpose: shared constants and types for the serial eeprom power-up write guard
// Assumes: 125 MHz system clock, spi mode 0 framing
// Notes: timing counts are derived from the printed times
package spgw_pkg;
    localparam int CLK_KHZ = 125000;
    localparam int POWERUP_RESET_INTERVAL_MS = 200;
    localparam int NV_WRITE_CYCLE_TIME_MS = 10;
    localparam int POWERUP_RESET_CYC = POWERUP_RESET_INTERVAL_MS * CLK_KHZ;
    localparam int NV_WRITE_CYC = NV_WRITE_CYCLE_TIME_MS * CLK_KHZ;
    localparam int MEM_WORDS = 512;
    localparam int PAGE_BYTES = 16;
    localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
    localparam logic [7:0] WRITE_LATCH_CLR_CMD = 8'h04;
    localparam logic [7:0] STATUS_READ_CMD = 8'h05;
    localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
    localparam logic [7:0] ARRAY_OP_MASK = 8'hF7;
    localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
    localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
    localparam int OP_A8_BIT = 3;
    localparam logic [1:0] WD_DEFAULT = 2'h3;
    localparam logic [1:0] BP_NONE = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [8:0] QUARTER_BASE = 9'h180;
    localparam logic [8:0] HALF_BASE = 9'h100;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SR_WD_LSB = 4;
    localparam int SR_BP_LSB = 2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CMD, ST_ADDR, ST_RD, ST_RDSR, ST_WR, ST_WRSR, ST_IGNORE
    } spgw_state_t;

    typedef struct packed {
        logic [2:0] cs_sy;
        logic [2:0] sck_sy;
        logic [1:0] si_sy;
        logic [1:0] wp_sy;
        spgw_state_t state;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic op_rd;
        logic a8;
        logic [8:0] addr;
        logic [7:0] tx;
        logic so;
        logic so_oe;
        logic wlatch;
        logic busy;
        logic flag;
        logic [1:0] bp;
        logic [1:0] wd;
        logic got_byte;
        logic [7:0] sr_data;
        logic sr_pend;
        logic [PAGE_BYTES-1:0][7:0] pbuf;
        logic [PAGE_BYTES-1:0] mask;
        logic [31:0] wr_cnt;
        logic [31:0] por_cnt;
        logic rst_n;
        logic [MEM_WORDS-1:0][7:0] mem;
    } spgw_regs_t;
endpackage

// file: tb/spgw_host_model.sv
// Purpose: spi host model driving the eeprom pins
// Assumes: mode 0, sck half period of 4 system clocks
// Notes: pins change on the falling system clock edge
`timescale 1ns/1ps
module spgw_host_model (
    input wire logic i_clk,
    input wire logic i_so,
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // nb below 8 stops the frame inside a byte
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            o_si = tx[i];
            hw(4);
            o_sck = 1'b1;
            hw(2);
            rx[i] = i_so;
            hw(2);
            o_sck = 1'b0;
        end
    endtask
    // sck idles low; a released data line shows the inverse of its last bit
    task automatic frame(input logic [7:0] op, input int na, input logic [7:0] a, input logic [7:0] d,
                         input int nb, output logic [7:0] v);
        o_cs_n = 1'b0;
        hw(4);
        xfer(op, 8, v);
        if (na > 0) xfer(a, 8, v);
        if (nb > 0) xfer(d, nb, v);
        hw(4);
        o_cs_n = 1'b1;
        o_si = ~o_si;
        hw(8);
    endtask
endmodule // spgw_host_model

// file: tb/test_spgw_core.sv
// Purpose: self-checking bench for the power-up write guard
// Assumes: shortened power-up and write-cycle counts
// Notes: busy length is counted by a monitor
`timescale 1ns/1ps
module test_spgw_core;
    import spgw_pkg::*;
    localparam int POR = 64;
    // short write cycle, still long enough to read status mid-cycle
    localparam int NV = 256;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_wp_n = 1'b1;
    logic i_flag_set = 1'b0;
    logic cs_n, sck, si, so, so_pin, so_oe, rst_n, busy, wlatch, flag;
    logic [1:0] psel;
    logic [7:0] rd;
    logic [7:0] exp_m [3];
    logic [8:0] a;
    int errors = 0;
    int comparisons = 0;
    int bcnt = 0;
    int bbase = 0;
    int n;
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) if (busy === 1'b1) bcnt <= bcnt + 1;
    // a released output reads as the inverse of its last bit, so a late enable shows up
    assign so_pin = so_oe ? so : ~so;
    spgw_core #(.P_POR_CYC(POR), .P_NV_CYC(NV)) u_spgw_core (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .i_flag_set(i_flag_set), .o_so(so),
        .o_so_oe(so_oe), .o_rst_n(rst_n), .o_write_busy_bit(busy), .o_write_enable_latch_bit(wlatch),
        .o_flag(flag), .o_protect_sel(psel));
    spgw_host_model u_spgw_host_model (.i_clk(i_clk), .i_so(so_pin), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic fr(input logic [7:0] op, input int na, input logic [8:0] ad, input logic [7:0] d,
                      input int nb);
        u_spgw_host_model.frame(op | {4'h0, ad[8], 3'h0}, na, ad[7:0], d, nb, rd);
    endtask
    // bounded wait for the write cycle, then its length in clocks
    task automatic wbusy(input int exp);
        n = 0;
        while (busy === 1'b1 && n < NV + 8) begin
            n++;
            @(negedge i_clk);
        end
        chk(bcnt - bbase, exp);
        bbase = bcnt;
    endtask
    ////////////////////////////////////////
    initial begin
        #400_000;
        errors++;
        end_sim();
    end
    initial begin
        exp_m = '{8'h00, 8'h00, 8'h00};
        repeat (3) @(negedge i_clk);
        chk({so_oe, wlatch, flag, rst_n, busy, psel}, 0);
        chk(32'(POWERUP_RESET_CYC >= 100 * CLK_KHZ && POWERUP_RESET_CYC <= 400 * CLK_KHZ), 1);
        chk(32'(NV_WRITE_CYC <= 10 * CLK_KHZ), 1);
        i_resetn = 1'b1;
        repeat (POR - 2) @(negedge i_clk);
        chk(rst_n, 0);
        repeat (4) @(negedge i_clk);
        chk(rst_n, 1);
        fr(STATUS_READ_CMD, 0, 9'h000, 8'h00, 8);
        chk(rd, 8'h30);
        chk(so_oe, 0);
        fr(ARRAY_WRITE_CMD, 1, 9'h010, 8'hA5, 8);
        wbusy(0);
        fr(WRITE_LATCH_SET_CMD, 0, 9'h000, 8'h00, 0);
        chk(wlatch, 1);
        fr(ARRAY_WRITE_CMD, 1, 9'h010, 8'h5A, 5);
        wbusy(0);
        fr(ARRAY_WRITE_CMD, 1, 9'h010, 8'hA5, 8);
        fr(STATUS_READ_CMD, 0, 9'h000, 8'h00, 8);
        chk(rd, 8'h33);
        wbusy(NV);
        chk(wlatch, 0);
        fr(ARRAY_READ_CMD, 1, 9'h010, 8'h00, 8);
        chk(rd, 8'hA5);
        fr(WRITE_LATCH_SET_CMD, 0, 9'h000, 8'h00, 0);
        i_wp_n = 1'b0;
        repeat (6) @(negedge i_clk);
        chk(wlatch, 0);
        fr(WRITE_LATCH_SET_CMD, 0, 9'h000, 8'h00, 0);
        fr(STATUS_WRITE_CMD, 0, 9'h000, 8'h3C, 8);
        wbusy(0);
        chk(psel, 0);
        i_wp_n = 1'b1;
        // every protect setting against a top-quarter, upper-half and low address
        for (int b = 0; b < 4; b++) begin
            fr(WRITE_LATCH_SET_CMD, 0, 9'h000, 8'h00, 0);
            fr(STATUS_WRITE_CMD, 0, 9'h000, 8'h30 | 8'(b << 2), 8);
            wbusy(NV);
            chk(psel, b);
            for (int k = 0; k < 3; k++) begin
                a = (k == 0) ? 9'h1F0 : (k == 1) ? 9'h140 : 9'h020;
                if (b == 0 || (b == 1 && k > 0) || (b == 2 && k == 2)) exp_m[k] = 8'(16 * b + k + 1);
                fr(WRITE_LATCH_SET_CMD, 0, 9'h000, 8'h00, 0);
                fr(ARRAY_WRITE_CMD, 1, a, 8'(16 * b + k + 1), 8);
                wbusy((exp_m[k] == 8'(16 * b + k + 1)) ? NV : 0);
                fr(ARRAY_READ_CMD, 1, a, 8'h00, 8);
                chk(rd, exp_m[k]);
            end
        end
        i_flag_set = 1'b1;
        @(negedge i_clk);
        i_flag_set = 1'b0;
        @(negedge i_clk);
        chk(flag, 1);
        fr(WRITE_LATCH_SET_CMD, 0, 9'h000, 8'h00, 0);
        i_resetn = 1'b0;
        @(negedge i_clk);
        chk({wlatch, flag, rst_n, busy, so_oe}, 0);
        i_resetn = 1'b1;
        // second power-up: the reset output must time out again and the latch stay clear
        repeat (POR - 2) @(negedge i_clk);
        chk(rst_n, 0);
        repeat (4) @(negedge i_clk);
        chk(rst_n, 1);
        fr(STATUS_READ_CMD, 0, 9'h000, 8'h00, 8);
        chk(rd & 8'h03, 8'h00);
        end_sim();
    end
endmodule // test_spgw_core
